// File: bench/eag_address_gen_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module eag_address_gen_monitor (
    // Clock, reset, request
    input wire        mclk_i,
    input wire        rst_b_i,
    input wire        start_i,
    input wire [15:0] pc_i,
    input wire [7:0]  opcode_i,
    input wire [7:0]  byte1_i,
    input wire [7:0]  byte2_i,
    input wire [7:0]  index_i,
    input wire        cond_i,
    input wire [7:0]  mem_byte_i,
    // Results
    input wire [1:0]  length_o,
    input wire [15:0] ea_o,
    input wire [7:0]  bit_mask_o,
    input wire        branch_taken_o,
    input wire [15:0] next_pc_o,
    input wire        carry_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    wire [3:0]  hi  = opcode_i[7:4];
    wire [15:0] rel = {{8{byte1_i[7]}}, byte1_i};
    wire [15:0] brt = {{8{byte2_i[7]}}, byte2_i};
    a_rel_target: assert property (start_i && hi == 4'h2 |=> branch_taken_o == $past(cond_i) &&
        next_pc_o == $past(pc_i) + 16'h2 + ($past(cond_i) ? $past(rel) : 16'h0)) else $error("rel target");
    a_ix_addr: assert property (start_i && (hi == 4'h7 || hi == 4'hf) |=>
        ea_o == {8'h00, $past(index_i)} && length_o == 2'h1) else $error("ix address");
    a_ix1_addr: assert property (start_i && (hi == 4'h6 || hi == 4'he) |=>
        ea_o == $past(index_i) + $past(byte1_i) && length_o == 2'h2) else $error("ix1 address");
    a_ix2_addr: assert property (start_i && hi == 4'hd |=>
        ea_o == {$past(byte1_i), $past(byte2_i)} + $past(index_i) && length_o == 2'h3) else $error("ix2 address");
    a_bsc_mask: assert property (start_i && hi == 4'h1 |=>
        bit_mask_o == 8'h1 << $past(opcode_i[3:1]) && ea_o == {8'h00, $past(byte1_i)}) else $error("bsc mask");
    a_btb_carry: assert property (start_i && hi == 4'h0 |=>
        carry_o == $past(mem_byte_i[opcode_i[3:1]]) && length_o == 2'h3) else $error("btb carry");
    a_btb_target: assert property (start_i && hi == 4'h0 |=>
        branch_taken_o == ($past(mem_byte_i[opcode_i[3:1]]) != $past(opcode_i[0])) &&
        next_pc_o == $past(pc_i) + 16'h3 +
        (($past(mem_byte_i[opcode_i[3:1]]) != $past(opcode_i[0])) ? $past(brt) : 16'h0)) else $error("btb target");
    a_inh_len: assert property (start_i && (hi == 4'h4 || hi == 4'h5) |=>
        length_o == 2'h1 && next_pc_o == $past(pc_i) + 16'h1) else $error("inherent length");
endmodule
bind eag_address_gen eag_address_gen_monitor mon_u (.mclk_i, .rst_b_i, .start_i, .pc_i, .opcode_i, .byte1_i,
    .byte2_i, .index_i, .cond_i, .mem_byte_i, .length_o, .ea_o, .bit_mask_o, .branch_taken_o, .next_pc_o, .carry_o);
`default_nettype wire

// File: bench/eag_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module eag_mem_model (
    // Page-zero address and read byte
    input  wire [7:0] addr_i,
    output wire [7:0] data_o
);
    // Distinct fixed byte per address
    assign data_o = addr_i ^ 8'ha5;
endmodule
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "eag_defines.vh"
module tb_top;
    reg         mclk_i = 1'b0;
    reg         rst_b_i = 1'b0;
    reg         start_i = 1'b0;
    reg         cond_i = 1'b0;
    reg         carry_i = 1'b0;
    reg  [15:0] pc_i = 16'h0;
    reg  [7:0]  opcode_i = 8'h0, byte1_i = 8'h0, byte2_i = 8'h0, index_i = 8'h0;
    wire [7:0]  mem_byte_i, bit_mask_o;
    wire        done_o, ea_valid_o, bit_set_o, branch_taken_o, carry_o;
    wire [3:0]  mode_o;
    wire [1:0]  length_o;
    wire [2:0]  bit_num_o;
    wire [15:0] ea_o, next_pc_o;
    integer     miscompares = 0, tests_run = 0, cycles = 0, i;
    eag_address_gen dut_u (.mclk_i, .rst_b_i, .start_i, .pc_i, .opcode_i, .byte1_i, .byte2_i, .index_i, .cond_i,
        .mem_byte_i, .carry_i, .done_o, .mode_o, .length_o, .ea_o, .ea_valid_o, .bit_num_o, .bit_mask_o,
        .bit_set_o, .branch_taken_o, .next_pc_o, .carry_o);
    eag_mem_model mem_u (.addr_i(byte1_i), .data_o(mem_byte_i));
    initial forever #20 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cycles = cycles + 1;
        if (cycles == 1000) begin
            miscompares = miscompares + 1;
            summarize;
        end
    end
    task chk(input string name, input [15:0] got, input [15:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One decode request, answer sampled a cycle later
    task issue(input [15:0] pc, input [7:0] op, b1, b2, ix, input c, input [1:0] len, input [3:0] md);
        @(negedge mclk_i);
        pc_i = pc;
        opcode_i = op;
        byte1_i = b1;
        byte2_i = b2;
        index_i = ix;
        cond_i = c;
        carry_i = c;
        start_i = 1'b1;
        @(negedge mclk_i);
        start_i = 1'b0;
        chk("done", done_o, 16'h1);
        chk("length", length_o, len);
        chk("mode", mode_o, md);
        chk("ea_valid", ea_valid_o, !(md == `EAG_MODE_INH || md == `EAG_MODE_IMM || md == `EAG_MODE_REL));
    endtask
    task t_rel;
        for (i = 0; i < 4; i = i + 1) begin
            issue(16'h0200, 8'h26, i[1] ? 8'h80 : 8'h7f, 8'h00, 8'h00, i[0], 2'h2, `EAG_MODE_REL);
            chk("rel_pc", next_pc_o, i[0] ? (i[1] ? 16'h0182 : 16'h0281) : 16'h0202);
            chk("rel_taken", branch_taken_o, i[0]);
        end
        $display("test rel done");
    endtask
    task t_modes;
        issue(16'h0300, 8'hf6, 8'h00, 8'h00, 8'h9c, 1'b0, 2'h1, `EAG_MODE_IX);
        chk("ix", ea_o, 16'h009c);
        issue(16'h0300, 8'he6, 8'hff, 8'h00, 8'hff, 1'b0, 2'h2, `EAG_MODE_IX1);
        chk("ix1", ea_o, 16'h01fe);
        issue(16'h0300, 8'hd6, 8'h12, 8'h34, 8'h10, 1'b0, 2'h3, `EAG_MODE_IX2);
        chk("ix2", ea_o, 16'h1244);
        issue(16'h0300, 8'hb6, 8'hfe, 8'h00, 8'h00, 1'b0, 2'h2, `EAG_MODE_DIR);
        chk("dir", ea_o, 16'h00fe);
        issue(16'h0300, 8'hc6, 8'h12, 8'h34, 8'h00, 1'b0, 2'h3, `EAG_MODE_EXT);
        chk("ext", ea_o, 16'h1234);
        issue(16'h0300, 8'ha6, 8'h42, 8'h00, 8'h00, 1'b1, 2'h2, `EAG_MODE_IMM);
        chk("imm_pc", next_pc_o, 16'h0302);
        chk("imm_taken", branch_taken_o, 16'h0);
        issue(16'h0300, 8'had, 8'hfe, 8'h00, 8'h00, 1'b0, 2'h2, `EAG_MODE_REL);
        chk("bsr_pc", next_pc_o, 16'h0300);
        chk("bsr_taken", branch_taken_o, 16'h1);
        issue(16'h0300, 8'h4c, 8'h55, 8'h66, 8'h00, 1'b1, 2'h1, `EAG_MODE_INH);
        chk("inh_pc", next_pc_o, 16'h0301);
        chk("inh_carry", carry_o, 16'h1);
        $display("test modes done");
    endtask
    task t_bits;
        reg b;
        for (i = 0; i < 16; i = i + 1) begin
            issue(16'h0400, i[7:0], 8'h30 + i[7:0], 8'h80, 8'h00, i[0], 2'h3, `EAG_MODE_BTB);
            b = mem_byte_i[i[3:1]];
            chk("carry", carry_o, b);
            chk("taken", branch_taken_o, b ^ i[0]);
            chk("target", next_pc_o, (b ^ i[0]) ? 16'h0383 : 16'h0403);
            chk("btb_ea", ea_o, 16'h0030 + i[15:0]);
            issue(16'h0500, 8'h10 + i[7:0], 8'h40, 8'h00, 8'h00, 1'b0, 2'h2, `EAG_MODE_BSC);
            chk("mask", bit_mask_o, 16'h1 << i[3:1]);
            chk("bsc_ea", ea_o, 16'h0040);
            chk("bit_num", bit_num_o, i[3:1]);
            chk("bit_set", bit_set_o, !i[0]);
        end
        $display("test bits done");
    endtask
    task summarize;
        $display("comparisons %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge mclk_i);
        rst_b_i = 1'b1;
        t_rel;
        t_modes;
        t_bits;
        summarize;
    end
endmodule
`default_nettype wire

// File: common/eag_defines.vh
`ifndef EAG_DEFINES_VH
`define EAG_DEFINES_VH

// Addressing modes
`define EAG_MODE_W     4
`define EAG_MODE_INH   4'h0
`define EAG_MODE_IMM   4'h1
`define EAG_MODE_DIR   4'h2
`define EAG_MODE_EXT   4'h3
`define EAG_MODE_REL   4'h4
`define EAG_MODE_IX    4'h5
`define EAG_MODE_IX1   4'h6
`define EAG_MODE_IX2   4'h7
`define EAG_MODE_BSC   4'h8
`define EAG_MODE_BTB   4'h9
`define EAG_MODE_BAD   4'hf

// Opcode high nibble groups
`define EAG_HI_BTB     4'h0
`define EAG_HI_BSC     4'h1
`define EAG_HI_REL     4'h2
`define EAG_HI_DIR     4'h3
`define EAG_HI_INHA    4'h4
`define EAG_HI_INHX    4'h5
`define EAG_HI_IX1     4'h6
`define EAG_HI_IX      4'h7
`define EAG_HI_INH8    4'h8
`define EAG_HI_INH9    4'h9
`define EAG_HI_IMM     4'ha
`define EAG_HI_RMDIR   4'hb
`define EAG_HI_RMEXT   4'hc
`define EAG_HI_RMIX2   4'hd
`define EAG_HI_RMIX1   4'he
`define EAG_HI_RMIX    4'hf

// Special low nibble in the immediate column: branch to subroutine
`define EAG_LO_BSR     4'hd

// Instruction lengths in bytes
`define EAG_LEN_1      2'h1
`define EAG_LEN_2      2'h2
`define EAG_LEN_3      2'h3

// Field positions in the opcode
`define EAG_OP_HI      7:4
`define EAG_OP_LO      3:0
`define EAG_OP_BIT     3:1
`define EAG_OP_POL     0

// Page-zero high byte
`define EAG_ZERO_PAGE  8'h00

`endif

// File: design/eag_address_gen.v
// How it works
// RL1: Relative branch adds signed offset byte to PC only when condition holds; BSR always branches.
// RL2: Two-byte branch reaches 126 below to 129 above the opcode address.
// RL3: Indexed no offset uses index register alone, one-byte instruction.
// RL4: Indexed 8-bit offset adds index and unsigned byte, two-byte instruction.
// RL5: Indexed 16-bit offset adds index and unsigned word, three-byte instruction.
// RL6: Bit set/clear takes bit from opcode, page-zero address from next byte.
// RL7: Bit test-and-branch is three bytes: opcode, direct address, signed offset.
// RL8: Bit test-and-branch taken when tested bit matches the opcode polarity.
// RL9: Tested bit always copied into carry flag, taken or not.
// RL10: Inherent instructions decode from the opcode alone, one byte long.
// RL11: Direct mode address is the byte after the opcode, two bytes.
// RL12: Extended mode address is the two bytes after the opcode, three bytes.
// RL13: Branch target is next instruction address plus sign-extended offset.
`timescale 1ns/1ps
`default_nettype none
`include "eag_defines.vh"

module eag_address_gen #(
    parameter AW = 16
) (
    // Clock and reset
    input  wire          mclk_i,
    input  wire          rst_b_i,
    // Instruction fields, valid with start_i
    input  wire          start_i,
    input  wire [AW-1:0] pc_i,
    input  wire [7:0]    opcode_i,
    input  wire [7:0]    byte1_i,
    input  wire [7:0]    byte2_i,
    input  wire [7:0]    index_i,
    // Branch condition and tested memory byte
    input  wire          cond_i,
    input  wire [7:0]    mem_byte_i,
    input  wire          carry_i,
    // Results
    output reg           done_o,
    output reg  [3:0]    mode_o,
    output reg  [1:0]    length_o,
    output reg  [AW-1:0] ea_o,
    output reg           ea_valid_o,
    output reg  [2:0]    bit_num_o,
    output reg  [7:0]    bit_mask_o,
    output reg           bit_set_o,
    output reg           branch_taken_o,
    output reg  [AW-1:0] next_pc_o,
    output reg           carry_o
);
    reg  [3:0]    next_mode;
    reg  [1:0]    next_len;
    reg  [AW-1:0] next_ea;
    reg           next_ea_valid;
    reg           next_taken;
    reg  [7:0]    next_offset;
    reg           next_carry;
    reg           tested_bit;
    wire [AW-1:0] seq_pc;
    wire [AW-1:0] tgt_pc;
    wire [3:0]    hi;
    wire [3:0]    lo;
    wire [2:0]    bit_sel;
    wire          want_set;
    reg  [AW-1:0] next_pc;
    reg  [7:0]    next_mask;
    wire [AW-1:0] zp_addr;
    wire [AW-1:0] abs_addr;
    wire [AW-1:0] ix_addr;
    wire [AW-1:0] ix1_addr;
    wire [AW-1:0] ix2_addr;

    assign hi       = opcode_i[`EAG_OP_HI];
    assign lo       = opcode_i[`EAG_OP_LO];
    assign bit_sel  = opcode_i[`EAG_OP_BIT];
    assign want_set = ~opcode_i[`EAG_OP_POL];

    // Operand addresses; sums wrap at the address width
    assign zp_addr  = {{(AW-8){1'b0}}, byte1_i};
    assign abs_addr = {byte1_i, byte2_i};
    assign ix_addr  = {{(AW-8){1'b0}}, index_i};
    assign ix1_addr = ix_addr + zp_addr;
    assign ix2_addr = abs_addr + ix_addr;

    eag_target_adder #(
        .AW(AW)
    ) u_adder (
        .pc_i     (pc_i),
        .len_i    (next_len),
        .offset_i (next_offset),
        .next_pc_o(seq_pc),
        .target_o (tgt_pc)
    );

    always @* begin
        next_mode     = `EAG_MODE_BAD;
        next_len      = `EAG_LEN_1;
        next_ea       = {AW{1'b0}};
        next_ea_valid = 1'b0;
        next_taken    = 1'b0;
        next_offset   = byte1_i;
        next_carry    = carry_i;
        tested_bit    = mem_byte_i[bit_sel];
        case (hi)
            `EAG_HI_BTB: begin
                next_mode     = `EAG_MODE_BTB;
                next_len      = `EAG_LEN_3;                             // [RL7]
                next_ea       = {{(AW-8){1'b0}}, byte1_i};              // [RL7]
                next_ea_valid = 1'b1;
                next_offset   = byte2_i;                                // [RL7]
                // Even opcodes branch on set, odd on clear
                next_taken    = (tested_bit == want_set);               // [RL8]
                next_carry    = tested_bit;                             // [RL9]
            end

            `EAG_HI_BSC: begin
                next_mode     = `EAG_MODE_BSC;
                next_len      = `EAG_LEN_2;                             // [RL6]
                next_ea       = {{(AW-8){1'b0}}, byte1_i};              // [RL6]
                next_ea_valid = 1'b1;
            end

            `EAG_HI_REL: begin
                next_mode  = `EAG_MODE_REL;
                next_len   = `EAG_LEN_2;                                // [RL2]
                next_taken = cond_i;                                    // [RL1]
            end

            `EAG_HI_DIR, `EAG_HI_RMDIR: begin
                next_mode     = `EAG_MODE_DIR;
                next_len      = `EAG_LEN_2;                             // [RL11]
                next_ea       = {{(AW-8){1'b0}}, byte1_i};              // [RL11]
                next_ea_valid = 1'b1;
            end

            `EAG_HI_RMEXT: begin
                next_mode     = `EAG_MODE_EXT;
                next_len      = `EAG_LEN_3;                             // [RL12]
                next_ea       = {byte1_i, byte2_i};                     // [RL12]
                next_ea_valid = 1'b1;
            end

            `EAG_HI_INHA, `EAG_HI_INHX, `EAG_HI_INH8, `EAG_HI_INH9: begin
                next_mode = `EAG_MODE_INH;
                next_len  = `EAG_LEN_1;                                 // [RL10]
            end

            `EAG_HI_IMM: begin
                if (lo == `EAG_LO_BSR) begin
                    next_mode  = `EAG_MODE_REL;
                    next_len   = `EAG_LEN_2;
                    next_taken = 1'b1;                                  // [RL1]
                end else begin
                    next_mode = `EAG_MODE_IMM;
                    next_len  = `EAG_LEN_2;
                end
            end

            `EAG_HI_IX, `EAG_HI_RMIX: begin
                next_mode     = `EAG_MODE_IX;
                next_len      = `EAG_LEN_1;                             // [RL3]
                next_ea       = {{(AW-8){1'b0}}, index_i};              // [RL3]
                next_ea_valid = 1'b1;
            end

            `EAG_HI_IX1, `EAG_HI_RMIX1: begin
                next_mode     = `EAG_MODE_IX1;
                next_len      = `EAG_LEN_2;                             // [RL4]
                next_ea       = ix1_addr;                               // [RL4]
                next_ea_valid = 1'b1;
            end

            `EAG_HI_RMIX2: begin
                next_mode     = `EAG_MODE_IX2;
                next_len      = `EAG_LEN_3;                             // [RL5]
                next_ea       = ix2_addr;                               // [RL5]
                next_ea_valid = 1'b1;
            end

            default: begin
                next_mode = `EAG_MODE_BAD;
            end
        endcase
    end

    // Address to load next and one-hot bit select
    always @* begin
        next_pc            = seq_pc;
        next_mask          = 8'h00;
        next_mask[bit_sel] = 1'b1;                                      // [RL6]
        if (next_taken) begin
            next_pc = tgt_pc;                                           // [RL13]
        end
    end

    always @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            done_o         <= 1'b0;
            mode_o         <= `EAG_MODE_INH;
            length_o       <= `EAG_LEN_1;
            ea_o           <= {AW{1'b0}};
            ea_valid_o     <= 1'b0;
            bit_num_o      <= 3'h0;
            bit_mask_o     <= 8'h00;
            bit_set_o      <= 1'b0;
            branch_taken_o <= 1'b0;
            next_pc_o      <= {AW{1'b0}};
            carry_o        <= 1'b0;
        end else begin
            done_o <= start_i;
            if (start_i) begin
                mode_o         <= next_mode;
                length_o       <= next_len;
                ea_o           <= next_ea;
                ea_valid_o     <= next_ea_valid;
                bit_num_o      <= bit_sel;                              // [RL6]
                bit_mask_o     <= next_mask;                            // [RL6]
                bit_set_o      <= want_set;
                branch_taken_o <= next_taken;
                next_pc_o      <= next_pc;                              // [RL13]
                carry_o        <= next_carry;                           // [RL9]
            end
        end
    end
endmodule

`default_nettype wire

// File: design/eag_target_adder.v
`timescale 1ns/1ps
`default_nettype none

// Next-instruction address and sign-extended branch target
module eag_target_adder #(
    parameter AW = 16
) (
    // Operands
    input  wire [AW-1:0] pc_i,
    input  wire [1:0]    len_i,
    input  wire [7:0]    offset_i,
    // Results
    output wire [AW-1:0] next_pc_o,
    output wire [AW-1:0] target_o
);
    wire [AW-1:0] len_ext;
    wire [AW-1:0] off_ext;

    assign len_ext   = {{(AW-2){1'b0}}, len_i};
    assign off_ext   = {{(AW-8){offset_i[7]}}, offset_i};
    assign next_pc_o = pc_i + len_ext;
    assign target_o  = next_pc_o + off_ext;
endmodule

`default_nettype wire
